// file: shared/nvic_pkg.sv
// Package for the nested vectored interrupt controller: register map, vector layout, constants.
// Assumes a 32-bit APB slave, one clock, synchronous active-high reset.
package nvic_pkg;
  localparam int NVIC_NUM_IRQ = 32;
  localparam int NVIC_PRIO_REGS = 8;
  localparam int NVIC_PRIO_W = 8;
  localparam int NVIC_PRIO_LVL_W = 2;
  localparam int NVIC_VEC_W = 6;
  localparam int NVIC_ADDR_W = 12;
  // Register byte offsets
  localparam logic [11:0] NVIC_ISER_OFS = 12'h000;
  localparam logic [11:0] NVIC_ICER_OFS = 12'h080;
  localparam logic [11:0] NVIC_ISPR_OFS = 12'h100;
  localparam logic [11:0] NVIC_ICPR_OFS = 12'h180;
  localparam logic [11:0] NVIC_IABR_OFS = 12'h200;
  localparam logic [11:0] NVIC_PRIO_OFS = 12'h300;
  localparam logic [11:0] NVIC_PRIO_END = 12'h31C;
  localparam logic [11:0] NVIC_CUR_OFS = 12'h400;
  // Vector table
  localparam logic [31:0] NVIC_VTOR_BASE = 32'h00000000;
  localparam logic [5:0] NVIC_MSP_VEC = 6'h00;
  localparam logic [5:0] NVIC_IRQ_VEC_BASE = 6'h10;
  localparam logic [4:0] NVIC_USB_IRQ = 5'h17;
  localparam logic [4:0] NVIC_WAKEUP_IRQ = 5'h1C;
  localparam logic [4:0] NVIC_RTC_IRQ = 5'h1F;
  localparam logic [7:0] NVIC_PRIO_RST = 8'h00;
  // Running priority when in thread mode: below every configurable level
  localparam logic [2:0] NVIC_IDLE_PRIO = 3'h4;
endpackage

// file: verif/nvic_core_model.sv
// Core exception logic model: takes offered vectors after a delay, issues returns on command.
// Assumes the request is a level held until entry_ack is seen.
module nvic_core_model (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic irq_req_in,
  input wire logic slow_in,
  input wire logic ret_cmd_in,
  output logic entry_ack_out,
  output logic exc_return_out
);
  logic [1:0] wait_r;
  wire logic [1:0] dly_w = slow_in ? 2'h3 : 2'h0;
  // Ack only a request seen standing the cycle before; the registered ack can still meet a withdrawn offer
  wire logic take_w = irq_req_in && !entry_ack_out && (wait_r >= dly_w);
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      wait_r <= 2'h0;
      entry_ack_out <= 1'b0;
      exc_return_out <= 1'b0;
    end else begin
      entry_ack_out <= take_w;
      wait_r <= (irq_req_in && !take_w && wait_r != 2'h3) ? wait_r + 2'h1 : 2'h0;
      exc_return_out <= ret_cmd_in;
    end
  end
endmodule

// file: verif/nvic_ctrl_props.sv
// Port checker for nvic_ctrl: vector fetch, entry, return and APB answers.
// Assumes it is bound to nvic_ctrl and sees only that module's ports.
module nvic_ctrl_props
  import nvic_pkg::*;
#(
  parameter int NUM_IRQ = NVIC_NUM_IRQ
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [NUM_IRQ-1:0] irq_line_in,
  input wire logic sys_exc_active_in,
  input wire logic irq_req_out,
  input wire logic [NVIC_VEC_W-1:0] irq_vector_out,
  input wire logic [31:0] vector_fetch_addr_out,
  input wire logic entry_ack_in,
  input wire logic exc_return_in,
  input wire logic [NVIC_VEC_W-1:0] cur_vector_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  wire logic acc_w = psel_in && penable_in;
  // Everything past the status word is unmapped
  wire logic unmapped_w = acc_w && (paddr_in > NVIC_CUR_OFS);
  sequence s_accept;
    irq_req_out && entry_ack_in;
  endsequence
  sequence s_pop;
    exc_return_in && (cur_vector_out != 6'h00);
  endsequence
  chk_fetch_addr: assert property (irq_req_out |->
    vector_fetch_addr_out == NVIC_VTOR_BASE + {24'h000000, irq_vector_out, 2'b00})
    else $error("fetch address does not match offered vector");
  chk_idle_vector: assert property (!irq_req_out |-> irq_vector_out == NVIC_MSP_VEC &&
    vector_fetch_addr_out == NVIC_VTOR_BASE) else $error("idle vector not zero");
  chk_vector_range: assert property (irq_req_out |-> irq_vector_out >= NVIC_IRQ_VEC_BASE)
    else $error("offered vector below peripheral range");
  chk_entry_active: assert property (s_accept |=> cur_vector_out == $past(irq_vector_out))
    else $error("accepted vector not made current");
  chk_return_pops: assert property (s_pop |=> cur_vector_out != $past(cur_vector_out))
    else $error("return did not pop the handler");
  chk_sys_blocks: assert property ($rose(irq_req_out) |-> !$past(sys_exc_active_in))
    else $error("request raised during system exception");
  chk_ready_now: assert property (psel_in |-> pready_out)
    else $error("slave inserted a wait state");
  chk_unmapped_err: assert property (unmapped_w |-> pslverr_out && (pwrite_in || prdata_out == 32'h0))
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (acc_w && paddr_in == NVIC_ISER_OFS |-> !pslverr_out)
    else $error("mapped access refused");
endmodule

bind nvic_ctrl nvic_ctrl_props #(.NUM_IRQ(NUM_IRQ)) u_props (.sys_clk_in(sys_clk_in),
  .srst_in(srst_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
  .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .irq_line_in(irq_line_in), .sys_exc_active_in(sys_exc_active_in),
  .irq_req_out(irq_req_out), .irq_vector_out(irq_vector_out),
  .vector_fetch_addr_out(vector_fetch_addr_out), .entry_ack_in(entry_ack_in),
  .exc_return_in(exc_return_in), .cur_vector_out(cur_vector_out));

// file: verif/testbench.sv
// Self-checking bench for nvic_ctrl: APB master, interrupt lines, core model.
// Assumes zero-wait-state APB answers and a 50 ns clock.
module testbench
  import nvic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_in, srst_in, psel, penable, pwrite, sys_exc, slow, ret_cmd, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, lines, rd;
  wire logic [31:0] prdata, fetch;
  wire logic pready, pslverr, req, ack, ret;
  wire logic [5:0] vec, cur;
  int failures, comparisons;
  nvic_ctrl dut (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .irq_line_in(lines),
    .sys_exc_active_in(sys_exc), .irq_req_out(req), .irq_vector_out(vec),
    .vector_fetch_addr_out(fetch), .entry_ack_in(ack), .exc_return_in(ret),
    .cur_vector_out(cur));
  nvic_core_model u_core (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .irq_req_in(req),
    .slow_in(slow), .ret_cmd_in(ret_cmd), .entry_ack_out(ack), .exc_return_out(ret));
  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  task automatic tally_and_finish;
    if (failures == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge sys_clk_in);
    penable <= 1'b1;
    @(posedge sys_clk_in);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge sys_clk_in);
      n++;
    end
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    if (n == 20) begin
      failures++;
      tally_and_finish();
    end
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic offer(input logic [5:0] v);
    int n;
    n = 0;
    while (req !== 1'b1 && n < 40) begin
      @(negedge sys_clk_in);
      n++;
    end
    chk({26'h0, vec}, {26'h0, v});
    chk(fetch, {24'h0, v, 2'b00});
    while (cur !== v && n < 80) begin
      @(negedge sys_clk_in);
      n++;
    end
    if (n >= 80) begin
      failures++;
      tally_and_finish();
    end
  endtask
  task automatic ret_pulse;
    @(posedge sys_clk_in);
    ret_cmd <= 1'b1;
    @(posedge sys_clk_in);
    ret_cmd <= 1'b0;
    repeat (3) @(negedge sys_clk_in);
  endtask
  task automatic t_reset;
    rdchk(NVIC_ISER_OFS, 32'h0);
    rdchk(NVIC_ISPR_OFS, 32'h0);
    rdchk(NVIC_PRIO_OFS, 32'h0);
    rdchk(NVIC_CUR_OFS, 32'h0);
    apb(1'b0, 12'h800, 32'h0);
    chk({rd[31:1], err}, 32'h1);
  endtask
  task automatic t_enable;
    apb(1'b1, NVIC_ISER_OFS, 32'h80800001);
    rdchk(NVIC_ICER_OFS, 32'h80800001);
    apb(1'b1, NVIC_ICER_OFS, 32'h00000001);
    rdchk(NVIC_ISER_OFS, 32'h80800000);
    apb(1'b1, NVIC_ICER_OFS, 32'h80800000);
    apb(1'b1, NVIC_PRIO_OFS + 12'h014, 32'hFFFFFFFF);
    rdchk(NVIC_PRIO_OFS + 12'h014, 32'hC0C0C0C0);
    apb(1'b1, NVIC_PRIO_END, 32'h00000040);
  endtask
  task automatic t_nest;
    @(posedge sys_clk_in);
    lines[28] <= 1'b1;
    repeat (6) @(negedge sys_clk_in);
    chk({31'h0, req}, 32'h0);
    rdchk(NVIC_ISPR_OFS, 32'h10000000);
    apb(1'b1, NVIC_ISER_OFS, 32'h90000000);
    offer(6'h2C);
    rdchk(NVIC_ICPR_OFS, 32'h0);
    lines[31] <= 1'b1;
    offer(6'h2F);
    apb(1'b1, NVIC_ICER_OFS, 32'h80000000);
    apb(1'b1, NVIC_ICPR_OFS, 32'hFFFFFFFF);
    rdchk(NVIC_IABR_OFS, 32'h90000000);
    ret_pulse();
    chk({26'h0, cur}, 32'h0000002C);
    apb(1'b1, NVIC_ISPR_OFS, 32'h80000000);
    repeat (4) @(negedge sys_clk_in);
    chk({31'h0, req}, 32'h0);
    rdchk(NVIC_ISPR_OFS, 32'h80000000);
    apb(1'b1, NVIC_ICPR_OFS, 32'h80000000);
    rdchk(NVIC_ICPR_OFS, 32'h0);
    ret_pulse();
    rdchk(NVIC_IABR_OFS, 32'h0);
  endtask
  task automatic t_usb;
    slow <= 1'b1;
    sys_exc <= 1'b1;
    apb(1'b1, NVIC_ISER_OFS, 32'h00800000);
    apb(1'b1, NVIC_ISPR_OFS, 32'h00800000);
    repeat (4) @(negedge sys_clk_in);
    chk({31'h0, req}, 32'h0);
    @(posedge sys_clk_in);
    sys_exc <= 1'b0;
    offer(6'h27);
    ret_pulse();
    chk({26'h0, cur}, 32'h0);
  endtask
  initial begin
    {srst_in, psel, penable, pwrite, sys_exc, slow, ret_cmd} = 7'h40;
    {paddr, pwdata, lines, failures, comparisons} = '0;
    repeat (8) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    t_reset();
    t_enable();
    t_nest();
    t_usb();
    tally_and_finish();
  end
endmodule

// file: verilog/nvic_ctrl.sv
// Contract
// - Vector table base is fixed at zero, never relocatable.
// - Word zero holds initial main stack pointer; word n holds vector n entry.
// - Accepted interrupt fetches handler address from the table automatically.
// - Write one to set-enable enables, to clear-enable disables; zeros ignored.
// - Both enable registers read back current enable state.
// - Line asserting while disabled becomes pending, not active.
// - Active interrupt stays active when disabled until return or reset.
// - Disabled interrupt never starts a new activation; an offer acknowledged in the cycle after its clear-enable write is still taken.
// - Set-pending and clear-pending write-one registers; both read pending state.
// - Clear-pending never changes active state.
// - Eight-bit priority field per interrupt, four per 32-bit register.
// - Wakeup uses interrupt 28 vector 44; calendar clock interrupt 31 vector 47.
// - USB device request uses interrupt 23, vector 39.
// - Thirty-two interrupts, four priority levels each.
// - Priority 0 most urgent, 3 least; below reset, NMI, hard fault.
//
// Interrupt controller core: APB register slave, pending/active tracking, arbitration,
// vector table fetch request toward the core. Assumes the core acknowledges entry and
// signals return with one-cycle pulses on sys_clk_in; irq lines are asynchronous levels.
module nvic_ctrl
  import nvic_pkg::*;
#(
  parameter int NUM_IRQ = NVIC_NUM_IRQ
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [NUM_IRQ-1:0] irq_line_in,
  input wire logic sys_exc_active_in,
  output logic irq_req_out,
  output logic [NVIC_VEC_W-1:0] irq_vector_out,
  output logic [31:0] vector_fetch_addr_out,
  input wire logic entry_ack_in,
  input wire logic exc_return_in,
  output logic [NVIC_VEC_W-1:0] cur_vector_out
);

  typedef enum logic [1:0] {NV_IDLE, NV_REQ} nvic_state_t;

  logic [NUM_IRQ-1:0] irq_meta_r;
  logic [NUM_IRQ-1:0] irq_sync_r;
  logic [NUM_IRQ-1:0] irq_prev_r;
  logic [NUM_IRQ-1:0] enable_r;
  logic [NUM_IRQ-1:0] pending_r;
  logic [NUM_IRQ-1:0] active_r;
  logic [NUM_IRQ-1:0] enable_nxt;
  logic [NUM_IRQ-1:0] pending_nxt;
  logic [NUM_IRQ-1:0] active_nxt;
  logic [NVIC_PRIO_W-1:0] prio_r [NUM_IRQ];
  logic [4:0] stack_id_r [4];
  logic [2:0] stack_prio_r [4];
  logic [2:0] depth_r;
  logic [4:0] sel_id_r;
  logic [2:0] sel_prio_r;
  nvic_state_t state_r;
  logic [31:0] prdata_r;

  // Bus decode
  wire logic wr_en = psel_in && penable_in && pwrite_in;
  wire logic rd_en = psel_in && penable_in && !pwrite_in;
  wire logic hit_iser = paddr_in == NVIC_ISER_OFS;
  wire logic hit_icer = paddr_in == NVIC_ICER_OFS;
  wire logic hit_ispr = paddr_in == NVIC_ISPR_OFS;
  wire logic hit_icpr = paddr_in == NVIC_ICPR_OFS;
  wire logic hit_iabr = paddr_in == NVIC_IABR_OFS;
  wire logic hit_cur = paddr_in == NVIC_CUR_OFS;
  wire logic hit_prio = paddr_in >= NVIC_PRIO_OFS && paddr_in <= NVIC_PRIO_END &&
                        paddr_in[1:0] == 2'h0;
  wire logic [2:0] prio_idx = paddr_in[4:2];
  wire logic hit_any = hit_iser || hit_icer || hit_ispr || hit_icpr || hit_iabr ||
                       hit_cur || hit_prio;
  wire logic [NUM_IRQ-1:0] wdata_w = pwdata_in[NUM_IRQ-1:0];
  wire logic [NUM_IRQ-1:0] set_en_w = (wr_en && hit_iser) ? wdata_w : '0;
  wire logic [NUM_IRQ-1:0] clr_en_w = (wr_en && hit_icer) ? wdata_w : '0;
  wire logic [NUM_IRQ-1:0] set_pend_w = (wr_en && hit_ispr) ? wdata_w : '0;
  wire logic [NUM_IRQ-1:0] clr_pend_w = (wr_en && hit_icpr) ? wdata_w : '0;
  wire logic [NUM_IRQ-1:0] rise_w = irq_sync_r & ~irq_prev_r;

  // Core handshake
  wire logic take_w = (state_r == NV_REQ) && entry_ack_in;
  wire logic ret_w = exc_return_in && (depth_r != 3'h0);
  wire logic [4:0] top_id_w = stack_id_r[2'(depth_r - 3'h1)];
  wire logic [2:0] run_prio_w = (depth_r == 3'h0) ? NVIC_IDLE_PRIO :
                                stack_prio_r[2'(depth_r - 3'h1)];

  // Per-interrupt candidacy and urgency, fed to the arbiter
  logic [NUM_IRQ-1:0] cand_w;
  logic [2:0] lvl_w [NUM_IRQ];
  genvar c;
  generate
    for (c = 0; c < NUM_IRQ; c++) begin : g_cand
      // Only enabled, pending, not-yet-active interrupts may start
      assign cand_w[c] = enable_r[c] && pending_r[c] && !active_r[c];
      // Two implemented bits give four levels; 0 is the most urgent
      assign lvl_w[c] = {1'b0, prio_r[c][7:6]};
    end
  endgenerate

  // Arbitration: lowest priority value wins, lowest number breaks ties
  logic [4:0] best_id;
  logic [2:0] best_prio;
  logic best_vld;
  always_comb begin
    best_id = 5'h00;
    best_prio = NVIC_IDLE_PRIO;
    best_vld = 1'b0;
    for (int i = 0; i < NUM_IRQ; i++) begin
      // Strict compare keeps the lower number on a tie
      if (cand_w[i] && lvl_w[i] < best_prio) begin
        best_id = 5'(i);
        best_prio = lvl_w[i];
        best_vld = 1'b1;
      end
    end
  end

  // Preempt only strictly above running level and never during a fixed-priority exception
  wire logic preempt_w = best_vld && (best_prio < run_prio_w) && !sys_exc_active_in;
  wire logic [NVIC_VEC_W-1:0] sel_vec_w = NVIC_IRQ_VEC_BASE + {1'b0, sel_id_r};

  // Per-interrupt enable, pending and active bits
  genvar b;
  generate
    for (b = 0; b < NUM_IRQ; b++) begin : g_bit
      wire logic taken_w = take_w && (sel_id_r == 5'(b));
      wire logic popped_w = ret_w && (top_id_w == 5'(b));
      wire logic raise_pend_w = rise_w[b] || set_pend_w[b];
      wire logic drop_pend_w = taken_w || clr_pend_w[b];
      // Clear-enable wins over a same-cycle set-enable
      assign enable_nxt[b] = (enable_r[b] || set_en_w[b]) && !clr_en_w[b];
      // Edge or set-pending wins over a same-cycle clear or acceptance
      assign pending_nxt[b] = raise_pend_w || (pending_r[b] && !drop_pend_w);
      // Only a return clears active; disabling or clear-pending leaves it set
      assign active_nxt[b] = taken_w || (active_r[b] && !popped_w);
      always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
          enable_r[b] <= 1'b0;
          pending_r[b] <= 1'b0;
          active_r[b] <= 1'b0;
        end else begin
          enable_r[b] <= enable_nxt[b];
          pending_r[b] <= pending_nxt[b];
          active_r[b] <= active_nxt[b];
        end
      end
    end
  endgenerate

  // Two-flop synchroniser; only the second stage feeds the edge detector
  always_ff @(posedge sys_clk_in) begin
    irq_meta_r <= irq_line_in;
    irq_sync_r <= irq_meta_r;
  end

  // Previous level starts low, matching the idle level of the lines
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      irq_prev_r <= '0;
    end else begin
      irq_prev_r <= irq_sync_r;
    end
  end

  // Priority fields, four per word
  genvar g;
  generate
    for (g = 0; g < NUM_IRQ; g++) begin : g_prio
      always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
          prio_r[g] <= NVIC_PRIO_RST;
        end else if (wr_en && hit_prio && prio_idx == 3'(g / 4)) begin
          // Only the two upper bits are implemented
          prio_r[g] <= {pwdata_in[(g % 4) * 8 + 7 -: 2], 6'h00};
        end
      end
    end
  endgenerate

  // Request sequencing
  nvic_state_t state_nxt;
  logic [4:0] sel_id_nxt;
  logic [2:0] sel_prio_nxt;
  always_comb begin
    state_nxt = state_r;
    sel_id_nxt = sel_id_r;
    sel_prio_nxt = sel_prio_r;
    unique case (state_r)
      NV_IDLE: begin
        // A return in flight changes the running level, so wait one cycle
        if (preempt_w && !ret_w) begin
          state_nxt = NV_REQ;
          sel_id_nxt = best_id;
          sel_prio_nxt = best_prio;
        end
      end
      NV_REQ: begin
        if (take_w) begin
          state_nxt = NV_IDLE;
        end else if (preempt_w) begin
          // Late arrival: a more urgent source, or a lower-numbered one at the same level, replaces the offered one
          sel_id_nxt = best_id;
          sel_prio_nxt = best_prio;
        end else begin
          // Offered source lost enable or pending, or a fixed-priority exception became active, before acceptance
          state_nxt = NV_IDLE;
        end
      end
    endcase
  end

  // Nesting stack: an entry and a return in one cycle replace the top entry,
  // so the popped handler never lingers underneath the new one
  wire logic push_w = take_w && !ret_w;
  wire logic pop_w = ret_w && !take_w;
  wire logic [2:0] depth_nxt = push_w ? depth_r + 3'h1 : pop_w ? depth_r - 3'h1 : depth_r;
  wire logic [1:0] push_idx_w = ret_w ? 2'(depth_r - 3'h1) : 2'(depth_r);

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      state_r <= NV_IDLE;
      depth_r <= 3'h0;
      sel_id_r <= 5'h00;
      sel_prio_r <= NVIC_IDLE_PRIO;
    end else begin
      state_r <= state_nxt;
      depth_r <= depth_nxt;
      sel_id_r <= sel_id_nxt;
      sel_prio_r <= sel_prio_nxt;
    end
  end

  // Stack words need no reset: depth marks which ones are live
  always_ff @(posedge sys_clk_in) begin
    if (take_w) begin
      stack_id_r[push_idx_w] <= sel_id_r;
      stack_prio_r[push_idx_w] <= sel_prio_r;
    end
  end

  // Read mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    if (hit_iser || hit_icer) begin
      rd_mux[NUM_IRQ-1:0] = enable_r;
    end else if (hit_ispr || hit_icpr) begin
      rd_mux[NUM_IRQ-1:0] = pending_r;
    end else if (hit_iabr) begin
      rd_mux[NUM_IRQ-1:0] = active_r;
    end else if (hit_cur) begin
      rd_mux = {23'h000000, depth_r, cur_vector_out};
    end else if (hit_prio) begin
      for (int k = 0; k < 4; k++) begin
        rd_mux[k * 8 +: 8] = prio_r[{prio_idx, 2'(k)}];
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      prdata_r <= 32'h00000000;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      prdata_r <= 32'h00000000;
    end else if (rd_en) begin
      prdata_r <= rd_mux;
    end
  end

  // Answers combinationally in the access phase so read data must be current
  assign prdata_out = rd_en ? rd_mux : prdata_r;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !hit_any;

  assign irq_req_out = state_r == NV_REQ;
  assign irq_vector_out = (state_r == NV_REQ) ? sel_vec_w : NVIC_MSP_VEC;
  // Handler entry is base plus four bytes per vector; word 0 is the stack pointer
  assign vector_fetch_addr_out = NVIC_VTOR_BASE + {24'h000000, irq_vector_out, 2'b00};
  assign cur_vector_out = (depth_r == 3'h0) ? NVIC_MSP_VEC :
                          NVIC_IRQ_VEC_BASE + {1'b0, top_id_w};
endmodule
